// ### rtl/lrab_consts.svh
`ifndef LRAB_CONSTS_SVH
`define LRAB_CONSTS_SVH

// Register byte offsets
`define LRAB_OFS_STATUS     4'h0
`define LRAB_OFS_RAM_INDEX  4'h4
`define LRAB_OFS_RAM_DATA   4'h8
`define LRAB_OFS_CTRL       4'hC

// Reset values
`define LRAB_CTRL_RESET     1'b1
`define LRAB_MODE_RESET     2'h0
`define LRAB_PIN_RESET      1'b1

// Drive-mode codes
`define LRAB_MODE_STATIC    2'h1
`define LRAB_MODE_MUX2      2'h2
`define LRAB_MODE_MUX3      2'h3
`define LRAB_MODE_MUX4      2'h0

// Display RAM size
`define LRAB_RAM_WORDS      7'h28

// Slave address, upper six bits; value is arbitrary
`define LRAB_SLAVE_ADDR_HI  6'h15

// Blink ratios, normal-power and power-saving
`define LRAB_BLINK_N1       92160
`define LRAB_BLINK_N2       184320
`define LRAB_BLINK_N3       368640
`define LRAB_BLINK_L1       15360
`define LRAB_BLINK_L2       30720
`define LRAB_BLINK_L3       61440

// Multiplex row period
`define LRAB_CLK_MHZ        20
`define LRAB_ROW_PERIOD_US  50
`define LRAB_ROW_CYCLES     (`LRAB_ROW_PERIOD_US * `LRAB_CLK_MHZ)

`endif

// ### rtl/lrab_pkg.sv
package lrab_pkg;

  typedef enum logic [2:0] {
    LRAB_IDLE = 3'b000,
    LRAB_ADDR = 3'b001,
    LRAB_CMD  = 3'b010,
    LRAB_DATA = 3'b011,
    LRAB_SKIP = 3'b100
  } lrab_rx_state_t;

  typedef logic [1:0] lrab_mode_t;
  typedef logic [3:0] lrab_word_t;

endpackage

// ### rtl/lrab_sync.sv
`timescale 1ns/1ps
`default_nettype none

module lrab_sync #(
  parameter int         WIDTH = 1,
  parameter logic       INIT  = 1'b1
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] pin,
  output var  logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_level;

  // A bit changes only once the second and third stages agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_level[i] = (s2[i] == s3[i]) ? s3[i] : level[i];
    end
  end

  // Three-stage chain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1    <= {WIDTH{INIT}};
      s2    <= {WIDTH{INIT}};
      s3    <= {WIDTH{INIT}};
      level <= {WIDTH{INIT}};
    end else begin
      s1    <= pin;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end

endmodule // lrab_sync

`default_nettype wire

// ### rtl/lrab_top.sv
// How it works
// - Display bytes are stored starting at the address loaded by the pointer command.
// - After each byte the pointer advances by 8, 4, 3 or 2 per mode.
// - RAM is written only when subaddress counter equals the hardware subaddress pins.
// - The device-select command loads the subaddress counter.
// - On subaddress mismatch the write is dropped but the pointer still advances.
// - Pointer overflow increments the subaddress counter, even mid-byte.
// - Output rows scan 0-3, 0-2, 0-1 or row 0 by drive mode.
// - Output bank select shows row 2, or rows 2-3, in static or 1:2.
// - Input bank select writes row 2, or rows 2-3, in static or 1:2.
// - Input and output bank selections are independent settings.
// - Normal-power blink divides the clock by 92160, 184320 or 368640.
// - Power-saving blink divides the clock by 15360, 30720 or 61440.
// - Blinking blanks and restores the whole display, except alternate-bank blink in static and 1:2; off shows it steadily.
// - Alternate-bank blink swaps displayed bank at blink rate in static and 1:2.
// - One bit per SCL pulse; SDA stable while SCL is high.
// - An SDA change while SCL is high is a control condition, not data.
// - SDA falling with SCL high is START; rising is STOP.
// - Drive-mode codes: 01 static, 10 1:2, 11 1:3, 00 1:4.
// - A command with bit 7 clear is the last; later bytes are data.
`include "lrab_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module lrab_top #(
  parameter int BLINK_N1 = `LRAB_BLINK_N1,
  parameter int BLINK_N2 = `LRAB_BLINK_N2,
  parameter int BLINK_N3 = `LRAB_BLINK_N3,
  parameter int BLINK_L1 = `LRAB_BLINK_L1,
  parameter int BLINK_L2 = `LRAB_BLINK_L2,
  parameter int BLINK_L3 = `LRAB_BLINK_L3
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output var  logic              hreadyout,
  output var  logic              hresp,
  output var  logic [31:0]       hrdata,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output var  logic              sda_out,
  output var  logic              sda_oe,
  input  wire logic              slave_addr_lsb,
  input  wire logic              hw_subaddr_bit0,
  input  wire logic              hw_subaddr_bit1,
  input  wire logic              hw_subaddr_bit2,
  output var  logic              power_saving_select,
  output var  lrab_pkg::lrab_mode_t drive_mode,
  output var  logic              bias_half,
  output var  logic              disp_on,
  output var  logic              blink_phase,
  output var  logic [1:0]        row_sel,
  output var  logic [39:0]       row_data
);
  import lrab_pkg::*;

  localparam int RAMN = 40;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic       scl_f;
  logic       sda_f;
  logic [3:0] straps;
  logic       scl_d;
  logic       sda_d;

  lrab_sync #(.WIDTH(1), .INIT(`LRAB_PIN_RESET)) u_scl (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     (scl_in),
    .level   (scl_f)
  );
  lrab_sync #(.WIDTH(1), .INIT(`LRAB_PIN_RESET)) u_sda (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     (sda_in),
    .level   (sda_f)
  );
  lrab_sync #(.WIDTH(4), .INIT(1'b0)) u_strap (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     ({slave_addr_lsb, hw_subaddr_bit2, hw_subaddr_bit1, hw_subaddr_bit0}),
    .level   (straps)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus conditions
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic [2:0] hw_sub;
  logic [7:0] rx_byte;

  assign scl_rise = scl_f & ~scl_d;
  assign scl_fall = ~scl_f & scl_d;
  assign start_c  = scl_f & scl_d & sda_d & ~sda_f;
  assign stop_c   = scl_f & scl_d & ~sda_d & sda_f;
  assign hw_sub   = straps[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // Receiver, command decoder and RAM writer state
  lrab_rx_state_t state;
  lrab_rx_state_t next_state;
  logic [3:0]  cnt, next_cnt;
  logic [6:0]  shift, next_shift;
  logic        ack_want, next_ack_want;
  logic        next_sda_oe;
  logic [6:0]  ptr, next_ptr;
  logic [2:0]  sub, next_sub;
  logic        next_power_saving;
  logic        disp_en, next_disp_en;
  logic        next_bias_half;
  lrab_mode_t  next_drive_mode;
  logic        in_bank, next_in_bank;
  logic        out_bank, next_out_bank;
  logic [1:0]  blink_sel, next_blink_sel;
  logic        alt_blink, next_alt_blink;
  lrab_word_t  ram [RAMN];
  lrab_word_t  next_ram [RAMN];
  logic        rx_en;

  logic [2:0]  bpw;
  logic [6:0]  inc;
  logic [1:0]  r;
  logic [6:0]  o;
  logic [6:0]  w;
  logic [6:0]  wa;
  logic [2:0]  wsub;
  logic [1:0]  rowofs;
  logic        banked;

  assign rx_byte = {shift, sda_f};

  // Bits per word and pointer step for the current drive mode
  always_comb begin
    case (drive_mode)
      `LRAB_MODE_STATIC: begin bpw = 3'd1; inc = 7'd8; end
      `LRAB_MODE_MUX2:   begin bpw = 3'd2; inc = 7'd4; end
      `LRAB_MODE_MUX3:   begin bpw = 3'd3; inc = 7'd3; end
      default:           begin bpw = 3'd4; inc = 7'd2; end
    endcase
    banked = (drive_mode == `LRAB_MODE_STATIC) || (drive_mode == `LRAB_MODE_MUX2);
  end

  // Byte reception, acknowledge, commands and display writes
  always_comb begin
    next_state        = state;
    next_cnt          = cnt;
    next_shift        = shift;
    next_ack_want     = ack_want;
    next_sda_oe       = sda_oe;
    next_ptr          = ptr;
    next_sub          = sub;
    next_power_saving = power_saving_select;
    next_disp_en      = disp_en;
    next_bias_half    = bias_half;
    next_drive_mode   = drive_mode;
    next_in_bank      = in_bank;
    next_out_bank     = out_bank;
    next_blink_sel    = blink_sel;
    next_alt_blink    = alt_blink;
    next_ram          = ram;
    r                 = 2'd0;
    o                 = 7'd0;
    w                 = 7'd0;
    wa                = 7'd0;
    wsub              = 3'd0;
    rowofs            = (in_bank && banked) ? 2'd2 : 2'd0;
    if (!rx_en || stop_c) begin
      next_state  = LRAB_IDLE;
      next_sda_oe = 1'b0;
    end else if (start_c) begin
      next_state  = LRAB_ADDR;
      next_cnt    = 4'd0;
      next_sda_oe = 1'b0;
    end else begin
      if (scl_rise) begin
        if (cnt == 4'd8) begin
          next_cnt = 4'd0;
        end else begin
          next_shift = rx_byte[6:0];
          next_cnt   = cnt + 4'd1;
        end
        if (cnt == 4'd7) begin
          next_ack_want = 1'b0;
          case (state)
            LRAB_ADDR: begin
              if (rx_byte[7:1] == {`LRAB_SLAVE_ADDR_HI, straps[3]} && !rx_byte[0]) begin
                next_state    = LRAB_CMD;
                next_ack_want = 1'b1;
              end else begin
                next_state = LRAB_SKIP;
              end
            end
            LRAB_CMD: begin
              next_ack_want = 1'b1;
              if (!rx_byte[6]) begin
                next_ptr = {1'b0, rx_byte[5:0]};
              end else if (!rx_byte[5]) begin
                next_power_saving = rx_byte[4];
                next_disp_en      = rx_byte[3];
                next_bias_half    = rx_byte[2];
                next_drive_mode   = rx_byte[1:0];
              end else if (rx_byte[4:3] == 2'b00) begin
                next_sub = rx_byte[2:0];
              end else if (rx_byte[4:2] == 3'b110) begin
                next_in_bank  = rx_byte[1];
                next_out_bank = rx_byte[0];
              end else if (rx_byte[4:3] == 2'b10) begin
                next_alt_blink = rx_byte[2];
                next_blink_sel = rx_byte[1:0];
              end
              if (!rx_byte[7]) begin
                next_state = LRAB_DATA;
              end
            end
            LRAB_DATA: begin
              next_ack_want = (sub == hw_sub);
              for (int k = 0; k < 8; k++) begin
                w    = ptr + o;
                wa   = (w >= `LRAB_RAM_WORDS) ? w - `LRAB_RAM_WORDS : w;
                wsub = (w >= `LRAB_RAM_WORDS) ? sub + 3'd1 : sub;
                if (wsub == hw_sub && wa < `LRAB_RAM_WORDS) begin
                  next_ram[wa[5:0]][r + rowofs] = rx_byte[7 - k];
                end
                if ({1'b0, r} == bpw - 3'd1) begin
                  r = 2'd0;
                  o = o + 7'd1;
                end else begin
                  r = r + 2'd1;
                end
              end
              w = ptr + inc;
              if (w >= `LRAB_RAM_WORDS) begin
                next_ptr = w - `LRAB_RAM_WORDS;
                next_sub = sub + 3'd1;
              end else begin
                next_ptr = w;
              end
            end
            default: begin
              next_ack_want = 1'b0;
            end
          endcase
        end
      end
      if (scl_fall) begin
        next_sda_oe = (cnt == 4'd8) && ack_want;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state               <= LRAB_IDLE;
      cnt                 <= 4'd0;
      shift               <= 7'd0;
      ack_want            <= 1'b0;
      sda_oe              <= 1'b0;
      sda_out             <= 1'b0;
      scl_d               <= 1'b1;
      sda_d               <= 1'b1;
      ptr                 <= 7'd0;
      sub                 <= 3'd0;
      power_saving_select <= 1'b0;
      disp_en             <= 1'b0;
      bias_half           <= 1'b0;
      drive_mode          <= `LRAB_MODE_RESET;
      in_bank             <= 1'b0;
      out_bank            <= 1'b0;
      blink_sel           <= 2'd0;
      alt_blink           <= 1'b0;
      for (int i = 0; i < RAMN; i++) begin
        ram[i] <= 4'h0;
      end
    end else begin
      state               <= next_state;
      cnt                 <= next_cnt;
      shift               <= next_shift;
      ack_want            <= next_ack_want;
      sda_oe              <= next_sda_oe;
      sda_out             <= 1'b0;
      scl_d               <= scl_f;
      sda_d               <= sda_f;
      ptr                 <= next_ptr;
      sub                 <= next_sub;
      power_saving_select <= next_power_saving;
      disp_en             <= next_disp_en;
      bias_half           <= next_bias_half;
      drive_mode          <= next_drive_mode;
      in_bank             <= next_in_bank;
      out_bank            <= next_out_bank;
      blink_sel           <= next_blink_sel;
      alt_blink           <= next_alt_blink;
      ram                 <= next_ram;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Row scan, blink timing and display output
  logic [9:0]  row_cnt, next_row_cnt;
  logic [1:0]  scan_row, next_scan_row;
  logic [18:0] blink_cnt, next_blink_cnt;
  logic [18:0] blink_half;
  logic        next_blink_phase;
  logic        eff_bank;
  logic [1:0]  next_row_sel;
  logic [39:0] next_row_data;
  logic        next_disp_on;
  logic [1:0]  last_row;

  always_comb begin
    case (drive_mode)
      `LRAB_MODE_STATIC: last_row = 2'd0;
      `LRAB_MODE_MUX2:   last_row = 2'd1;
      `LRAB_MODE_MUX3:   last_row = 2'd2;
      default:           last_row = 2'd3;
    endcase
    case ({power_saving_select, blink_sel})
      3'b001:  blink_half = 19'(BLINK_N1 / 2);
      3'b010:  blink_half = 19'(BLINK_N2 / 2);
      3'b011:  blink_half = 19'(BLINK_N3 / 2);
      3'b101:  blink_half = 19'(BLINK_L1 / 2);
      3'b110:  blink_half = 19'(BLINK_L2 / 2);
      3'b111:  blink_half = 19'(BLINK_L3 / 2);
      default: blink_half = 19'd0;
    endcase
    next_row_cnt   = row_cnt + 10'd1;
    next_scan_row  = scan_row;
    if (row_cnt == 10'(`LRAB_ROW_CYCLES - 1)) begin
      next_row_cnt  = 10'd0;
      next_scan_row = (scan_row >= last_row) ? 2'd0 : scan_row + 2'd1;
    end
    // Half-period toggle gives one full blink cycle per ratio
    next_blink_cnt   = blink_cnt + 19'd1;
    next_blink_phase = blink_phase;
    if (blink_sel == 2'd0) begin
      next_blink_cnt   = 19'd0;
      next_blink_phase = 1'b0;
    end else if (blink_cnt >= blink_half - 19'd1) begin
      next_blink_cnt   = 19'd0;
      next_blink_phase = ~blink_phase;
    end
    eff_bank      = banked && (out_bank ^ (alt_blink && blink_phase));
    next_row_sel  = (scan_row > last_row ? 2'd0 : scan_row) + (eff_bank ? 2'd2 : 2'd0);
    for (int i = 0; i < RAMN; i++) begin
      next_row_data[i] = ram[i][next_row_sel];
    end
    next_disp_on = disp_en && !(blink_phase && !(alt_blink && banked));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      row_cnt     <= 10'd0;
      scan_row    <= 2'd0;
      blink_cnt   <= 19'd0;
      blink_phase <= 1'b0;
      row_sel     <= 2'd0;
      row_data    <= 40'h00_0000_0000;
      disp_on     <= 1'b0;
    end else begin
      row_cnt     <= next_row_cnt;
      scan_row    <= next_scan_row;
      blink_cnt   <= next_blink_cnt;
      blink_phase <= next_blink_phase;
      row_sel     <= next_row_sel;
      row_data    <= next_row_data;
      disp_on     <= next_disp_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY
  logic        wr_pend, next_wr_pend;
  logic [3:0]  waddr, next_waddr;
  logic [5:0]  ram_index, next_ram_index;
  logic        next_rx_en;
  logic [31:0] next_hrdata;
  logic        take;

  assign take = hsel && htrans[1] && hready;

  always_comb begin
    next_wr_pend   = take && hwrite && (hsize == 3'b010);
    next_waddr     = haddr[3:0];
    next_ram_index = ram_index;
    next_rx_en     = rx_en;
    next_hrdata    = hrdata;
    if (wr_pend) begin
      case (waddr)
        `LRAB_OFS_RAM_INDEX: next_ram_index = hwdata[5:0];
        `LRAB_OFS_CTRL:      next_rx_en     = hwdata[0];
        default:             next_ram_index = ram_index;
      endcase
    end
    if (take && !hwrite) begin
      case (haddr[3:0])
        `LRAB_OFS_STATUS:    next_hrdata = {blink_sel, blink_phase, 1'b0, alt_blink,
                                            disp_on, state, in_bank, out_bank, bias_half,
                                            power_saving_select, disp_en, drive_mode,
                                            5'd0, sub, 1'b0, ptr};
        `LRAB_OFS_RAM_INDEX: next_hrdata = {26'd0, ram_index};
        `LRAB_OFS_RAM_DATA:  next_hrdata = (ram_index < 6'd40) ? {28'd0, ram[ram_index]} : 32'h0000_0000;
        `LRAB_OFS_CTRL:      next_hrdata = {31'd0, rx_en};
        default:             next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      waddr     <= 4'h0;
      ram_index <= 6'd0;
      rx_en     <= `LRAB_CTRL_RESET;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= next_wr_pend;
      waddr     <= next_waddr;
      ram_index <= next_ram_index;
      rx_en     <= next_rx_en;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule // lrab_top

`default_nettype wire

// ### verification/lrab_checker.sv
`include "lrab_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module lrab_checker (
  input wire logic                 hclk,
  input wire logic                 hresetn,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire logic                 scl_in,
  input wire logic                 sda_out,
  input wire logic                 sda_oe,
  input wire lrab_pkg::lrab_mode_t drive_mode,
  input wire logic                 blink_phase,
  input wire logic [1:0]           row_sel
);
  import lrab_pkg::*;
  logic [10:0] settle;
  logic [10:0] next_settle;
  lrab_mode_t  last_mode;
  lrab_mode_t  next_last_mode;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////
  // Cycles since the drive mode last changed, saturating
  always_comb begin
    next_last_mode = drive_mode;
    next_settle    = settle + {10'h000, ~&settle};
    if (drive_mode != last_mode) begin
      next_settle = 11'h000;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle    <= 11'h000;
      last_mode <= 2'h0;
    end else begin
      settle    <= next_settle;
      last_mode <= next_last_mode;
    end
  end
  ////////////////////////////////////////////////////////////////
  property p_bus_okay; $past(hresetn) |-> hreadyout && !hresp; endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus slave stalled or not OKAY");
  property p_sda_low; sda_out == 1'b0; endproperty
  a_sda_low: assert property (p_sda_low) else $error("open-drain data driven high");
  property p_oe_scl_low; $changed(sda_oe) |-> !scl_in && !$past(scl_in); endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data line moved while clock high");
  property p_oe_hold; $rose(sda_oe) |=> sda_oe [*8]; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("acknowledge too short");
  property p_oe_gap; $fell(sda_oe) |=> !sda_oe [*8]; endproperty
  a_oe_gap: assert property (p_oe_gap) else $error("acknowledges too close");
  property p_row_pace; $changed(row_sel) |=> $stable(row_sel) [*8]; endproperty
  a_row_pace: assert property (p_row_pace) else $error("row scan steps too fast");
  property p_row_static; settle > 11'h4B0 && drive_mode == `LRAB_MODE_STATIC |-> row_sel inside {2'h0, 2'h2}; endproperty
  a_row_static: assert property (p_row_static) else $error("static mode shows odd row");
  property p_blink_pace; $changed(blink_phase) |=> $stable(blink_phase) [*6]; endproperty
  a_blink_pace: assert property (p_blink_pace) else $error("blink phase toggles too fast");
endmodule // lrab_checker
bind lrab_top lrab_checker lrab_checker_i (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .drive_mode(drive_mode), .blink_phase(blink_phase),
  .row_sel(row_sel));
`default_nettype wire

// ### verification/lrab_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
module lrab_i2c_master #(
  parameter int HALF = 10
) (
  input  wire logic hclk,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda
);
  // Both lines released while idle
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic wait_half();
    repeat (HALF) @(posedge hclk);
  endtask
  // Data moves only while clock low, one bit per pulse
  task automatic bit_out(input logic b, output logic s);
    sda <= b;
    wait_half();
    scl <= 1'b1;
    wait_half();
    s = sda_line;
    scl <= 1'b0;
    wait_half();
  endtask
  // Start only from an idle bus
  task automatic start();
    wait_half();
    sda <= 1'b0;
    wait_half();
    scl <= 1'b0;
    wait_half();
  endtask
  task automatic stop();
    sda <= 1'b0;
    wait_half();
    scl <= 1'b1;
    wait_half();
    sda <= 1'b1;
    wait_half();
  endtask
  // Eight bits MSB first, then sample acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i], s);
    end
    bit_out(1'b1, s);
    ack = ~s;
  endtask
endmodule // lrab_i2c_master
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lrab_pkg::*;
  localparam int N1 = 64;
  localparam int L1 = 16;
  logic        hclk, hresetn, hwrite, hreadyout, hresp, scl, sda_m, sda_out, sda_oe;
  logic        ps, disp_on, blink_phase, bias_half;
  logic [1:0]  htrans, row_sel;
  logic [39:0] row_data;
  logic [2:0]  sub;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [15:0] acks;
  lrab_mode_t  drive_mode;
  wire logic   sda_w = sda_m & ~sda_oe;
  int          errors, num_checks;
  lrab_top #(.BLINK_N1(N1), .BLINK_N2(128), .BLINK_N3(256), .BLINK_L1(L1), .BLINK_L2(32), .BLINK_L3(64)) lrab_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .slave_addr_lsb(1'b0), .hw_subaddr_bit0(sub[0]),
    .hw_subaddr_bit1(sub[1]), .hw_subaddr_bit2(sub[2]), .power_saving_select(ps), .drive_mode(drive_mode),
    .bias_half(bias_half), .disp_on(disp_on), .blink_phase(blink_phase), .row_sel(row_sel), .row_data(row_data));
  lrab_i2c_master mst_i (.hclk(hclk), .sda_line(sda_w), .scl(scl), .sda(sda_m));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One single AHB transfer, waiting on hready in both phases
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic ram(input logic [31:0] idx, output logic [31:0] d);
    ahb(1'b1, 32'h0000_0004, idx, d);
    ahb(1'b0, 32'h0000_0008, 32'h0000_0000, d);
  endtask
  task automatic xfer(input logic [7:0] q[$]);
    logic a;
    acks = 16'h0000;
    mst_i.start();
    mst_i.wbyte(8'h54, a);
    acks[0] = a;
    foreach (q[i]) begin
      mst_i.wbyte(q[i], a);
      acks[i+1] = a;
    end
    mst_i.stop();
  endtask
  task automatic measure(input int half);
    int   n;
    logic p, d;
    n = 0;
    p = blink_phase;
    while (blink_phase === p && n < 1000) begin @(negedge hclk); n++; end
    p = blink_phase;
    repeat (2) @(negedge hclk);
    d = disp_on;
    n = 2;
    while (blink_phase === p && n < 1000) begin @(negedge hclk); n++; end
    chk("blink half period", 32'(half), 32'(n));
    repeat (2) @(negedge hclk);
    chk("display blanking", {31'h0, ~d}, {31'h0, disp_on});
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic test_regs();
    ahb(1'b0, 32'h0000_0000, 32'h0000_0000, v);
    chk("status reset", 32'h0000_0000, v & 32'h03FF_FFFF);
    ahb(1'b0, 32'h0000_000C, 32'h0000_0000, v);
    chk("ctrl reset", 32'h0000_0001, v);
    ahb(1'b1, 32'h0000_0000, 32'hFFFF_FFFF, v);
    ram(32'h0000_002A, v);
    chk("ram beyond end", 32'h0000_0000, v);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000, v);
    chk("ram index", 32'h0000_002A, v);
    ahb(1'b0, 32'h0000_0000, 32'h0000_0000, v);
    chk("status read only", 32'h0000_0000, v & 32'h03FF_FFFF);
    $display("test regs done");
  endtask
  task automatic test_static();
    xfer('{8'hC9, 8'h05, 8'hA5});
    chk("acks", 32'h0000_000F, {16'h0000, acks});
    ahb(1'b0, 32'h0000_0000, 32'h0000_0000, v);
    chk("pointer", 32'h0000_000D, v & 32'h0000_007F);
    chk("mode", 32'h0000_0001, {30'h0, drive_mode});
    chk("display on", 32'h0000_0001, {31'h0, disp_on});
    for (int i = 0; i < 8; i++) begin
      ram(32'(5 + i), v);
      chk("static word", 32'((8'hA5 >> (7 - i)) & 8'h01), v);
    end
    $display("test static done");
  endtask
  task automatic test_wrap();
    sub <= 3'h1;
    xfer('{8'hC8, 8'hE1, 8'h26, 8'hFF, 8'hFF});
    chk("acks", 32'h0000_001F, {16'h0000, acks});
    ahb(1'b0, 32'h0000_0000, 32'h0000_0000, v);
    chk("pointer", 32'h0000_0002, v & 32'h0000_007F);
    chk("subaddress", 32'h0000_0002, (v >> 8) & 32'h0000_0007);
    ram(32'h0000_0026, v);
    chk("word 38", 32'h0000_000F, v);
    ram(32'h0000_0027, v);
    chk("word 39", 32'h0000_000F, v);
    ram(32'h0000_0000, v);
    chk("word 0", 32'h0000_0000, v);
    $display("test wrap done");
  endtask
  task automatic test_bank();
    xfer('{8'hC9, 8'hE1, 8'hFA, 8'hF1, 8'h00, 8'h80});
    chk("acks", 32'h0000_007F, {16'h0000, acks});
    ram(32'h0000_0000, v);
    chk("input bank word", 32'h0000_0004, v);
    ahb(1'b0, 32'h0000_0000, 32'h0000_0000, v);
    chk("banks", 32'h0040_0000, v & 32'h0060_0000);
    measure(N1 / 2);
    xfer('{8'h55});
    chk("display disabled", 32'h0000_0000, {31'h0, disp_on});
    xfer('{8'h5D});
    chk("power saving", 32'h0000_0001, {31'h0, ps});
    chk("bias", 32'h0000_0001, {31'h0, bias_half});
    measure(L1 / 2);
    chk("row select", 32'h0000_0000, {30'h0, row_sel});
    chk("row data low", 32'h0000_14A0, row_data[31:0]);
    chk("row data high", 32'h0000_00C0, {24'h0, row_data[39:32]});
    $display("test bank done");
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Clock, 50 ns period
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge hclk);
    errors++;
    $display("ERROR watchdog expected finish seen timeout");
    end_of_test();
  end
  // Main sequence
  initial begin
    hresetn = 1'b0;
    haddr   = 32'h0000_0000;
    hwdata  = 32'h0000_0000;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    sub     = 3'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    test_regs();
    test_static();
    test_wrap();
    test_bank();
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
